/* File: rtl/adc_port_pkg.sv */
`default_nettype none
package adc_port_pkg;
   // Word and pipeline shape
   localparam int CODE_W = 14;
   localparam int NSTAGE = 4;
   localparam int LATENCY = 5;
   localparam int PIPE_DEPTH = 2 * LATENCY;
   localparam int CORR_IDX = NSTAGE + 1;
   localparam int PUSH_IDX = PIPE_DEPTH - 1;
   localparam int SYNC_DEPTH = 3;
   localparam int FIFO_DEPTH = 8;
   localparam int MSB_IDX = CODE_W - 1;

   // Clamp codes for out-of-range conversions
   localparam logic [CODE_W-1:0] CODE_MAX = 14'h3fff;
   localparam logic [CODE_W-1:0] CODE_MIN = 14'h0000;

   // Bits resolved by each pipelined stage, coarse first
   localparam logic [CODE_W-1:0] STAGE_MASK [NSTAGE] = '{14'h3c00, 14'h03c0, 14'h0038, 14'h0007};

   // Quantised analog input, offset binary, with range detectors
   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic over;
      logic under;
   } analog_t;

   // Everything arriving from pins
   typedef struct packed {
      logic enc_p;
      logic enc_n;
      logic fmt;
      logic oe_b;
      analog_t analog;
   } pin_t;

   // One pipeline slot
   typedef struct packed {
      logic valid;
      logic [CODE_W-1:0] code;
      logic [CODE_W-1:0] residue;
      logic over;
      logic under;
   } pipe_t;

   // Corrected result
   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic ovf;
   } word_t;

   localparam int WORD_W = $bits(word_t);
endpackage
`default_nettype wire

/* File: rtl/result_fifo.sv */
`default_nettype none
module result_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [WIDTH-1:0] head_q, head_d;
   logic head_vld_q, head_vld_d;
   logic push, load;

   assign in_ready_o = (cnt_q != FULL_CNT);
   assign out_valid_o = head_vld_q;
   assign out_data_o = head_q;
   assign push = in_valid_i && in_ready_o;
   // Head register refills when empty or being taken
   assign load = (cnt_q != '0) && (!head_vld_q || out_ready_i);

   // Pointer, count and head next values
   always_comb
   begin
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      head_d = head_q;
      head_vld_d = head_vld_q;
      if (head_vld_q && out_ready_i)
      begin
         head_vld_d = 1'b0;
      end
      if (load)
      begin
         head_d = mem_q[rd_q];
         head_vld_d = 1'b1;
         rd_d = (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
      end
      if (push)
      begin
         wr_d = (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
      end
      cnt_d = cnt_q + CW'(push) - CW'(load);
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge sys_clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         head_q <= '0;
         head_vld_q <= 1'b0;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         head_q <= head_d;
         head_vld_q <= head_vld_d;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/pipelined_adc_output_port.sv */
// Summary of operation
// [RQ1] Format select low inverts the top code bit: two's complement output.
// [RQ2] Format select high leaves the top bit alone: offset binary output.
// [RQ3] Each sample is taken on the rising edge of the sample trigger.
// [RQ4] Encode pair is high when true exceeds complement, low when below.
// [RQ5] Output enable low drives the data bus; high floats it.
// [RQ6] Capture logic registers code and flag on the strobe's rising edge.
// [RQ7] Range exceed flag is high for any over- or under-range conversion.
// [RQ8] Result is a 14-bit word, bit 13 most significant, bit 0 least.
// [RQ9] Four pipelined stages; result appears five encode cycles after sampling.
// [RQ10] Input tracks while encode is low, frozen at the low-to-high edge.
// [RQ11] Samples advance one stage per encode phase, stages alternating.
// [RQ12] Earlier stage results are delayed, aligned and corrected before output.
// [RQ13] Code and flag update together once per cycle, stable at strobe rise.
`default_nettype none
module pipelined_adc_output_port #(
   parameter int FIFO_DEPTH = adc_port_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Encode pair from pins
   input wire logic sample_trigger_p_i,
   input wire logic sample_trigger_n_i,
   // Quantised analog input
   input wire adc_port_pkg::analog_t analog_i,
   // Control pins
   input wire logic top_bit_flip_select_i,
   input wire logic out_drive_b_i,
   // Drain stall from local logic
   input wire logic out_hold_i,
   // Output bus
   output logic [adc_port_pkg::CODE_W-1:0] sample_code_bits_o,
   output logic sample_code_bits_oe_b_o,
   output logic range_exceed_flag_o,
   output logic data_valid_strobe_o,
   output logic result_lost_o
);
   adc_port_pkg::pin_t sync_q [adc_port_pkg::SYNC_DEPTH];
   adc_port_pkg::pin_t sync_d [adc_port_pkg::SYNC_DEPTH];
   adc_port_pkg::pin_t pins_q, pins_d;
   adc_port_pkg::pipe_t pipe_q [adc_port_pkg::PIPE_DEPTH];
   adc_port_pkg::pipe_t pipe_d [adc_port_pkg::PIPE_DEPTH];
   adc_port_pkg::word_t push_word, head_word;
   logic enc_lvl_q, enc_lvl_d, enc_now, rise, fall;
   logic edge_q, edge_d;
   logic push_vld, push_rdy, head_vld, drain;
   logic [adc_port_pkg::CODE_W-1:0] code_q, code_d;
   logic oe_b_q, oe_b_d, flag_q, flag_d, strobe_q, strobe_d, lost_q, lost_d;

   // Pin word at reset: encode low, offset binary and a floated bus, so the
   // first clocks after release neither see a false encode edge nor drive the bus
   localparam adc_port_pkg::pin_t PIN_IDLE = '{
      enc_p: 1'b0,
      enc_n: 1'b1,
      fmt: 1'b1,
      oe_b: 1'b1,
      analog: '0
   };

   // Three-flop pin synchroniser; a change is taken once stages 2 and 3 agree
   // The whole pin word must agree, so analog and encode land in the same clock,
   // at the cost of one more clock of delay when two pins move close together
   always_comb
   begin
      sync_d[0] = '{enc_p: sample_trigger_p_i, enc_n: sample_trigger_n_i,
                    fmt: top_bit_flip_select_i, oe_b: out_drive_b_i, analog: analog_i};
      for (int i = 1; i < adc_port_pkg::SYNC_DEPTH; i++)
      begin
         sync_d[i] = sync_q[i-1];
      end
      pins_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : pins_q;
   end

   // Pair equal means no decision, so the level holds
   // Only a level change makes an edge; a slow crossing cannot double count
   always_comb
   begin
      enc_now = enc_lvl_q;
      if (pins_q.enc_p && !pins_q.enc_n)
      begin
         enc_now = 1'b1; // RQ4
      end
      else if (!pins_q.enc_p && pins_q.enc_n)
      begin
         enc_now = 1'b0; // RQ4
      end
      enc_lvl_d = enc_now;
      rise = enc_now && !enc_lvl_q; // RQ3
      fall = !enc_now && enc_lvl_q;
      edge_d = rise || fall;
   end

   // Phase pipeline: slot 0 is the hold capacitor, slots 1..4 the stages
   always_comb
   begin
      for (int i = 0; i < adc_port_pkg::PIPE_DEPTH; i++)
      begin
         pipe_d[i] = pipe_q[i];
      end
      if (rise || fall) // RQ11
      begin
         for (int i = 1; i < adc_port_pkg::PIPE_DEPTH; i++)
         begin
            pipe_d[i] = pipe_q[i-1];
         end
         for (int s = 0; s < adc_port_pkg::NSTAGE; s++)
         begin
            // Stage resolves its slice; earlier slices ride along delayed
            pipe_d[s+1].code = pipe_q[s].code | (pipe_q[s].residue & adc_port_pkg::STAGE_MASK[s]); // RQ12
            pipe_d[s+1].residue = pipe_q[s].residue & ~adc_port_pkg::STAGE_MASK[s]; // RQ11
         end
         // Correction clamps out-of-range results to the end codes
         if (pipe_q[adc_port_pkg::NSTAGE].over)
         begin
            pipe_d[adc_port_pkg::CORR_IDX].code = adc_port_pkg::CODE_MAX; // RQ12
         end
         else if (pipe_q[adc_port_pkg::NSTAGE].under)
         begin
            pipe_d[adc_port_pkg::CORR_IDX].code = adc_port_pkg::CODE_MIN; // RQ12
         end
         // Held on the rising edge, tracking again from the falling edge
         pipe_d[0] = '0; // RQ10
         if (rise)
         begin
            pipe_d[0].valid = 1'b1; // RQ10
            pipe_d[0].residue = pins_q.analog.code;
            pipe_d[0].over = pins_q.analog.over;
            pipe_d[0].under = pins_q.analog.under;
         end
      end
   end

   // Last slot enters the FIFO on the falling edge of the fifth cycle
   // Pushing one clock after the shift reads the slot once it has settled
   assign push_vld = edge_q && pipe_q[adc_port_pkg::PUSH_IDX].valid; // RQ9
   assign push_word.code = pipe_q[adc_port_pkg::PUSH_IDX].code;
   assign push_word.ovf = pipe_q[adc_port_pkg::PUSH_IDX].over
                          || pipe_q[adc_port_pkg::PUSH_IDX].under; // RQ7
   assign drain = rise && !out_hold_i;

   // Slack for a stalled drain; the head word waits in its own register,
   // so the output stage never reads the storage array directly
   result_fifo #(
      .WIDTH(adc_port_pkg::WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(push_vld),
      .in_ready_o(push_rdy),
      .in_data_i(push_word),
      .out_valid_o(head_vld),
      .out_ready_i(drain),
      .out_data_o(head_word)
   );

   // Output stage: data move at encode rise, strobe rises half a cycle later
   always_comb
   begin
      code_d = code_q;
      flag_d = flag_q;
      strobe_d = strobe_q;
      oe_b_d = pins_q.oe_b; // RQ5
      // A full FIFO drops the word; the loss stays visible until reset
      lost_d = lost_q || (push_vld && !push_rdy);
      if (drain && head_vld)
      begin
         code_d = head_word.code; // RQ8
         code_d[adc_port_pkg::MSB_IDX] = head_word.code[adc_port_pkg::MSB_IDX]
                                         ^ !pins_q.fmt; // RQ1 RQ2
         flag_d = head_word.ovf; // RQ13
         strobe_d = 1'b0; // RQ13
      end
      // A stall leaves the strobe high, so capture logic sees no extra edge
      else if (fall)
      begin
         strobe_d = 1'b1; // RQ13
      end
   end

   // One register bank for all state; reset loads constants only
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         for (int i = 0; i < adc_port_pkg::SYNC_DEPTH; i++)
         begin
            sync_q[i] <= PIN_IDLE;
         end
         for (int i = 0; i < adc_port_pkg::PIPE_DEPTH; i++)
         begin
            pipe_q[i] <= '0;
         end
         pins_q <= PIN_IDLE; // RQ5
         enc_lvl_q <= 1'b0;
         edge_q <= 1'b0;
         code_q <= '0;
         flag_q <= 1'b0;
         strobe_q <= 1'b0;
         oe_b_q <= 1'b1;
         lost_q <= 1'b0;
      end
      else
      begin
         sync_q <= sync_d;
         pipe_q <= pipe_d;
         pins_q <= pins_d;
         enc_lvl_q <= enc_lvl_d;
         edge_q <= edge_d;
         code_q <= code_d;
         flag_q <= flag_d;
         strobe_q <= strobe_d;
         oe_b_q <= oe_b_d;
         lost_q <= lost_d;
      end
   end

   // Every output comes straight off a register
   assign sample_code_bits_o = code_q;
   assign sample_code_bits_oe_b_o = oe_b_q; // RQ5
   assign range_exceed_flag_o = flag_q;
   assign data_valid_strobe_o = strobe_q; // RQ6
   assign result_lost_o = lost_q;
endmodule
`default_nettype wire

/* File: tb/adc_port_asserts.sv */
`default_nettype none
module adc_port_asserts (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Control pin and local drain stall
   input wire logic out_drive_b_i,
   input wire logic out_hold_i,
   // Output bus
   input wire logic [adc_port_pkg::CODE_W-1:0] sample_code_bits_o,
   input wire logic sample_code_bits_oe_b_o,
   input wire logic range_exceed_flag_o,
   input wire logic data_valid_strobe_o,
   input wire logic result_lost_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Strobe phases span several clocks at the bench encode rate
   sequence s_hi3; data_valid_strobe_o [*3]; endsequence
   sequence s_lo3; !data_valid_strobe_o [*3]; endsequence
   property p_hi_width; $rose(data_valid_strobe_o) |-> s_hi3; endproperty
   property p_lo_width; $fell(data_valid_strobe_o) |-> s_lo3; endproperty
   // Whole word, top bit too: format is applied only when a word is drained
   property p_quiet;
      data_valid_strobe_o |-> $stable(sample_code_bits_o) && $stable(range_exceed_flag_o);
   endproperty
   property p_oe; $stable(out_drive_b_i) [*8] |-> sample_code_bits_oe_b_o == out_drive_b_i;
   endproperty
   property p_oe_rise; $rose(out_drive_b_i) |-> ##[1:7] sample_code_bits_oe_b_o; endproperty
   property p_oe_fall; $fell(out_drive_b_i) |-> ##[1:7] !sample_code_bits_oe_b_o; endproperty
   property p_reset;
      $rose(rst_b_i) |-> sample_code_bits_o == '0 && !range_exceed_flag_o
         && !data_valid_strobe_o && sample_code_bits_oe_b_o && !result_lost_o;
   endproperty
   property p_hold;
      out_hold_i |=> $stable(sample_code_bits_o) && $stable(range_exceed_flag_o);
   endproperty
   a_hi_width: assert property (p_hi_width) else $error("strobe high too short");
   a_lo_width: assert property (p_lo_width) else $error("strobe low too short");
   a_quiet: assert property (p_quiet) else $error("word moved while strobe high");
   a_oe: assert property (p_oe) else $error("bus enable not following pin");
   a_oe_rise: assert property (p_oe_rise) else $error("bus not floated in time");
   a_oe_fall: assert property (p_oe_fall) else $error("bus not driven in time");
   a_reset: assert property (p_reset) else $error("bad values after reset");
   a_hold: assert property (p_hold) else $error("word updated while held");
endmodule
bind pipelined_adc_output_port adc_port_asserts chk_u (.sys_clk_i(sys_clk_i),
   .rst_b_i(rst_b_i), .out_drive_b_i(out_drive_b_i), .out_hold_i(out_hold_i),
   .sample_code_bits_o(sample_code_bits_o), .sample_code_bits_oe_b_o(sample_code_bits_oe_b_o),
   .range_exceed_flag_o(range_exceed_flag_o), .data_valid_strobe_o(data_valid_strobe_o),
   .result_lost_o(result_lost_o));
`default_nettype wire

/* File: tb/capture_model.sv */
`default_nettype none
module capture_model (
   // Bus as seen on the board
   input wire logic [adc_port_pkg::CODE_W-1:0] code_i,
   input wire logic flag_i,
   input wire logic strobe_i,
   // Captured word
   output var adc_port_pkg::word_t word_o,
   output var int count_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Latch on the strobe rise only, like a register in capture logic
   always @(posedge strobe_i)
   begin
      word_o <= '{code: code_i, ovf: flag_i};
      count_o <= count_o + 1;
   end
endmodule
`default_nettype wire

/* File: tb/pipelined_adc_output_port_test.sv */
`default_nettype none
module pipelined_adc_output_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rst_b = 0, trig_p = 0, trig_n = 1, fmt = 1, drv_b = 0, hold = 0;
   logic cmp_on = 1, oe_b, flag, strobe, lost;
   logic [31:0] seed = 32'hcb99;
   logic [adc_port_pkg::CODE_W-1:0] code, bus;
   adc_port_pkg::analog_t ana = '0;
   adc_port_pkg::analog_t smp_q[$];
   adc_port_pkg::word_t cap;
   int cap_n;
   int rises = 0, fails = 0, n_checks = 0, cyc = 0;
   pipelined_adc_output_port #(.FIFO_DEPTH(8)) dut_u (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
      .sample_trigger_p_i(trig_p), .sample_trigger_n_i(trig_n), .analog_i(ana),
      .top_bit_flip_select_i(fmt), .out_drive_b_i(drv_b), .out_hold_i(hold),
      .sample_code_bits_o(code), .sample_code_bits_oe_b_o(oe_b), .range_exceed_flag_o(flag),
      .data_valid_strobe_o(strobe), .result_lost_o(lost));
   // Floated bus shows the inverse so stale data never passes
   assign bus = code ^ {adc_port_pkg::CODE_W{oe_b}};
   capture_model cap_u (.code_i(bus), .flag_i(flag), .strobe_i(strobe), .word_o(cap),
      .count_o(cap_n));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic bad(input string m);
      fails++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic give_verdict;
      if (fails == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Reference word: clamp, flag, then top bit by current format
   task automatic check_word(input adc_port_pkg::analog_t a);
      logic [adc_port_pkg::CODE_W-1:0] c;
      c = a.over ? adc_port_pkg::CODE_MAX : (a.under ? adc_port_pkg::CODE_MIN : a.code);
      c[adc_port_pkg::MSB_IDX] = c[adc_port_pkg::MSB_IDX] ^ !fmt;
      n_checks++;
      if (cap !== {c, a.over | a.under}) bad("captured word");
   endtask
   initial forever #4 sys_clk = ~sys_clk;
   // Encode pair at 80 ns, ten system clocks, moved just after clock edges
   initial
   begin
      @(posedge rst_b);
      forever
      begin
         @(posedge sys_clk);
         trig_p <= 1'b1;
         trig_n <= 1'b0;
         smp_q.push_back(ana);
         rises++;
         repeat (5) @(posedge sys_clk);
         trig_p <= 1'b0;
         trig_n <= 1'b1;
         seed = xs(seed);
         ana.code <= seed[13:0];
         ana.over <= seed[18:16] == 3'h0;
         ana.under <= seed[21:19] == 3'h0 && seed[18:16] != 3'h0;
         repeat (4) @(posedge sys_clk);
      end
   end
   // The strobe raised before the first result carries no sample
   always @(cap_n)
      if (cmp_on && rises >= 6 && smp_q.size() > 0)
         check_word(smp_q.pop_front());
   // Hang guard
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         bad("timeout");
         give_verdict;
      end
   end
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1;
      repeat (150) @(posedge sys_clk);
      hold <= 1;
      drv_b <= 1;
      repeat (12) @(posedge sys_clk);
      n_checks++;
      if (oe_b !== 1'b1) bad("bus not floated");
      // Format moves only once the last pending strobe has been captured
      fmt <= 0;
      drv_b <= 0;
      repeat (40) @(posedge sys_clk);
      n_checks++;
      if (oe_b !== 1'b0 || lost !== 1'b0) bad("bus or loss flag");
      hold <= 0;
      repeat (200) @(posedge sys_clk);
      n_checks++;
      if (cap_n < 25) bad("too few strobes");
      cmp_on <= 0;
      hold <= 1;
      repeat (250) @(posedge sys_clk);
      n_checks++;
      if (lost !== 1'b1) bad("overflow not flagged");
      give_verdict;
   end
endmodule
`default_nettype wire
